// file: design/rtp_pkg.sv
// constants and types for the rtc output, supply and trim register block
package rtp_pkg;
	// register offsets on the two-wire bus
	localparam logic [7:0] REG_STATUS = 8'h07;
	localparam logic [7:0] REG_INT = 8'h08;
	localparam logic [7:0] REG_MAIN = 8'h09;
	localparam logic [7:0] REG_BATT = 8'h0a;
	localparam logic [7:0] REG_TRIM = 8'h0b;
	localparam logic [7:0] REG_UNMAPPED = 8'h00;
	// bit positions and field layouts
	localparam int STAT_LOW_MAIN_SUPPLY_FLAG_BIT = 3;
	localparam int INT_FOBAT_BIT = 4;
	localparam int FO_LSB = 0;
	localparam int FO_W = 4;
	localparam int MAIN_CLR_BIT = 7;
	localparam int LVL_W = 3;
	localparam int BROWN_LSB = 0;
	localparam int BATT_DISC_BIT = 6;
	localparam int B1_LSB = 3;
	localparam int B2_LSB = 0;
	localparam int AT_LSB = 0;
	localparam int AT_W = 6;
	localparam int DT_LSB = 6;
	localparam int DT_W = 2;
	// highest legal level codes, above are reserved
	localparam logic [2:0] BROWN_MAX = 3'h5;
	localparam logic [2:0] BATT_MAX = 3'h6;
	// coarse trim codes
	localparam logic [1:0] DT_PLUS = 2'h1;
	localparam logic [1:0] DT_MINUS = 2'h3;
	// output frequency codes and divider taps
	localparam logic [3:0] FO_OFF = 4'h0;
	localparam logic [3:0] FO_OSC = 4'h1;
	localparam int DIV_W = 20;
	localparam int SEC_W = 15;
	localparam logic [4:0] FO_TAP [16] = '{5'h00, 5'h00, 5'h02, 5'h04, 5'h08, 5'h09,
		5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e, 5'h0f, 5'h10, 5'h11, 5'h12, 5'h13};
	// slave address, arbitrary value
	localparam logic [6:0] DEV_ADDR = 7'h5a;
	// synchroniser lanes
	localparam int PIN_SCL = 0;
	localparam int PIN_SDA = 1;
	localparam int PIN_OSC = 2;
	localparam int PIN_BAT = 3;
	localparam int PIN_BROWN = 4;
	localparam int PIN_PWRUP = 5;
	localparam int PIN_ALARM = 6;
	localparam int NPIN = 7;
	localparam logic [3:0] BYTE_BITS = 4'h8;
	// serial engine states
	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_DEV = 5'b00010,
		ST_PTR = 5'b00100,
		ST_WR = 5'b01000,
		ST_RD = 5'b10000
	} rtp_state_type;
endpackage

// file: design/rtp_ctrl.sv
// register bank, serial slave and pin logic for rtc output, supply and trim
// What this block does
// - backup supply with disable bit: pins off
// - disable bit clear: pins work on backup
// - output code zero gives static output
// - codes 1-3 give 32768, 4096, 1024 Hz
// - codes 4-7 give 64 to 8 Hz
// - codes 8-15 give 4 to 1/32 Hz
// - stamp clear write clears both stamps
// - brownout select picks six main thresholds
// - below threshold on main supply: flag set, reset pin low
// - disconnect bit cuts backup supply pin
// - main power-up clears disconnect bit
// - first battery select, seven levels
// - second battery select, seven levels
// - digital trim skips or inserts pulses
// - coarse trim codes: none, +30.5, 0, -30.5
// - digital plus analog trim span range
// - fine trim field drives capacitor bank
`timescale 1ns/1ps
`default_nettype none
module rtp_ctrl (
	input wire logic core_clk, // 200 MHz clock
	input wire logic rst_n, // power-up reset, active low
	input wire logic scl_in, // serial clock pin
	input wire logic sda_in, // serial data pin level
	output logic sda_out, // serial data drive value
	output logic sda_oe, // serial data pulls low
	input wire logic osc_32k, // oscillator clock
	input wire logic battery_mode, // running from backup supply
	input wire logic main_below_trip, // comparator: main under threshold
	input wire logic main_power_up, // main supply came up
	input wire logic alarm_irq_n, // alarm logic asks for irq
	output logic fout_out, // frequency pin drive value
	output logic fout_oe, // frequency pin pulls low
	output logic irq_out, // irq pin drive value
	output logic irq_oe, // irq pin pulls low
	output logic low_supply_reset_pin_n, // low supply reset pin
	output logic low_main_supply_flag, // status flag
	output logic stamp_clear, // clears both time stamps
	output logic [2:0] brownout_level_select, // to main comparator
	output logic [2:0] batt_first_level_select, // to battery comparator
	output logic [2:0] batt_second_level_select, // to battery comparator
	output logic battery_disconnect, // isolates backup pin
	output logic [5:0] fine_analog_trim, // capacitor bank code
	output logic [1:0] coarse_digital_trim, // digital trim code
	output logic trim_insert, // insert one oscillator pulse
	output logic trim_skip // skip one oscillator pulse
);
	import rtp_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] sync1;
	logic [NPIN-1:0] sync2;
	logic [NPIN-1:0] sync3;
	logic [NPIN-1:0] filt;
	logic [NPIN-1:0] filt_d;
	logic [NPIN-1:0] next_filt;
	logic [NPIN-1:0] rise;
	logic [NPIN-1:0] fall;

	assign pin_raw = {alarm_irq_n, main_power_up, main_below_trip, battery_mode, osc_32k,
		sda_in, scl_in};
	// a lane changes only once stages two and three agree
	assign next_filt = ((sync2 ~^ sync3) & sync2) | ((sync2 ^ sync3) & filt);
	assign rise = filt & ~filt_d;
	assign fall = ~filt & filt_d;

	// reset to ones: idle bus, no alarm
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sync1 <= '1;
			sync2 <= '1;
			sync3 <= '1;
			filt <= '1;
			filt_d <= '1;
		end else begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			filt <= next_filt;
			filt_d <= filt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// serial slave: address, pointer, then data with auto increment
	rtp_state_type state;
	logic [3:0] bit_cnt;
	logic ack_phase;
	logic [7:0] shreg;
	logic [7:0] ptr;
	logic [7:0] rd_data;
	logic scl_f;
	logic sda_f;
	logic start_c;
	logic stop_c;
	logic byte_done;
	logic ack_end;
	logic wr_en;
	logic zero_drive;
	logic backup_pin_disable;
	logic [3:0] out_freq_select;

	assign scl_f = filt[PIN_SCL];
	assign sda_f = filt[PIN_SDA];
	assign start_c = fall[PIN_SDA] && scl_f && filt_d[PIN_SCL];
	assign stop_c = rise[PIN_SDA] && scl_f && filt_d[PIN_SCL];
	assign byte_done = fall[PIN_SCL] && !ack_phase && (bit_cnt == BYTE_BITS);
	assign ack_end = fall[PIN_SCL] && ack_phase;
	assign wr_en = byte_done && (state == ST_WR);

	// read mux; unmapped offsets read as zero
	assign rd_data = (ptr == REG_STATUS) ? (8'(low_main_supply_flag) << STAT_LOW_MAIN_SUPPLY_FLAG_BIT) :
		(ptr == REG_INT) ? {3'h0, backup_pin_disable, out_freq_select} :
		(ptr == REG_MAIN) ? {5'h00, brownout_level_select} :
		(ptr == REG_BATT) ? {1'b0, battery_disconnect, batt_first_level_select,
			batt_second_level_select} :
		(ptr == REG_TRIM) ? {coarse_digital_trim, fine_analog_trim} : REG_UNMAPPED;

	// shared shift register: bits in on rise; in reads it also shifts out
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_IDLE;
			bit_cnt <= 4'h0;
			ack_phase <= 1'b0;
			shreg <= 8'h00;
			ptr <= 8'h00;
			sda_oe <= 1'b0;
		end else if (start_c) begin
			state <= ST_DEV;
			bit_cnt <= 4'h0;
			ack_phase <= 1'b0;
			sda_oe <= 1'b0;
		end else if (stop_c) begin
			state <= ST_IDLE;
			ack_phase <= 1'b0;
			sda_oe <= 1'b0;
		end else if (state != ST_IDLE) begin
			if (rise[PIN_SCL] && !ack_phase) begin
				shreg <= {shreg[6:0], sda_f};
				bit_cnt <= bit_cnt + 4'h1;
			end else if (rise[PIN_SCL] && (state == ST_RD) && sda_f) begin
				// master said no more: let go of the bus
				state <= ST_IDLE;
			end
			if (ack_end) begin
				ack_phase <= 1'b0;
				bit_cnt <= 4'h0;
				if (state == ST_RD) begin
					shreg <= rd_data;
					sda_oe <= !rd_data[7];
					ptr <= ptr + 8'h01;
				end else begin
					sda_oe <= 1'b0;
				end
			end else if (byte_done) begin
				ack_phase <= 1'b1;
				unique case (state)
					ST_DEV: begin
						if (shreg[7:1] == DEV_ADDR) begin
							sda_oe <= 1'b1;
							state <= shreg[0] ? ST_RD : ST_PTR;
						end else begin
							sda_oe <= 1'b0;
							state <= ST_IDLE;
						end
					end
					ST_PTR: begin
						sda_oe <= 1'b1;
						ptr <= shreg;
						state <= ST_WR;
					end
					ST_WR: begin
						sda_oe <= 1'b1;
						ptr <= ptr + 8'h01;
					end
					ST_RD: begin
						sda_oe <= 1'b0;
					end
				endcase
			end else if (fall[PIN_SCL]) begin
				sda_oe <= (state == ST_RD) && !shreg[7];
			end
		end
	end

	// open-drain pins only ever pull low
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			zero_drive <= 1'b0;
		end else begin
			zero_drive <= 1'b0;
		end
	end
	assign sda_out = zero_drive;
	assign fout_out = zero_drive;
	assign irq_out = zero_drive;

	////////////////////////////////////////////////////////////////////////
	// register bank
	logic [2:0] wr_brown;
	logic [2:0] wr_b1;
	logic [2:0] wr_b2;

	assign wr_brown = shreg[BROWN_LSB +: LVL_W];
	assign wr_b1 = shreg[B1_LSB +: LVL_W];
	assign wr_b2 = shreg[B2_LSB +: LVL_W];

	// stamp clear self-clears, so it always reads back zero
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			backup_pin_disable <= 1'b0;
			out_freq_select <= FO_OFF;
			stamp_clear <= 1'b0;
			brownout_level_select <= 3'h0;
			battery_disconnect <= 1'b0;
			batt_first_level_select <= 3'h0;
			batt_second_level_select <= 3'h0;
			coarse_digital_trim <= 2'h0;
			fine_analog_trim <= 6'h00;
		end else begin
			stamp_clear <= wr_en && (ptr == REG_MAIN) && shreg[MAIN_CLR_BIT];
			if (wr_en && (ptr == REG_INT)) begin
				backup_pin_disable <= shreg[INT_FOBAT_BIT];
				out_freq_select <= shreg[FO_LSB +: FO_W];
			end
			if (wr_en && (ptr == REG_MAIN) && (wr_brown <= BROWN_MAX)) begin
				brownout_level_select <= wr_brown;
			end
			// power-up wins over a host write
			if (rise[PIN_PWRUP]) begin
				battery_disconnect <= 1'b0;
			end else if (wr_en && (ptr == REG_BATT)) begin
				battery_disconnect <= shreg[BATT_DISC_BIT];
			end
			if (wr_en && (ptr == REG_BATT) && (wr_b1 <= BATT_MAX)) begin
				batt_first_level_select <= wr_b1;
			end
			if (wr_en && (ptr == REG_BATT) && (wr_b2 <= BATT_MAX)) begin
				batt_second_level_select <= wr_b2;
			end
			// fine trim and coarse code held for the oscillator
			if (wr_en && (ptr == REG_TRIM)) begin
				coarse_digital_trim <= shreg[DT_LSB +: DT_W];
				fine_analog_trim <= shreg[AT_LSB +: AT_W];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// divider, output pin and trim pulses
	logic [DIV_W-1:0] div;
	logic tap_level;
	logic pins_on;
	logic sec_tick;
	logic low_main_supply_flag_now;

	assign tap_level = (out_freq_select == FO_OSC) ? filt[PIN_OSC] :
		div[FO_TAP[out_freq_select]];
	// pins follow the disable bit only on backup
	assign pins_on = !(filt[PIN_BAT] && backup_pin_disable);
	assign sec_tick = rise[PIN_OSC] && (div[SEC_W-1:0] == '1);
	// detection runs only on main supply
	assign low_main_supply_flag_now = filt[PIN_BROWN] && !filt[PIN_BAT];

	// ripple-free binary divider on oscillator edges
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			div <= '0;
		end else if (rise[PIN_OSC]) begin
			div <= div + 1'b1;
		end
	end

	// pin drivers and status, all registered
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fout_oe <= 1'b0;
			irq_oe <= 1'b0;
			low_main_supply_flag <= 1'b0;
			low_supply_reset_pin_n <= 1'b0;
			trim_insert <= 1'b0;
			trim_skip <= 1'b0;
		end else begin
			// code zero leaves the pin released
			fout_oe <= pins_on && (out_freq_select != FO_OFF) && !tap_level;
			irq_oe <= pins_on && !filt[PIN_ALARM];
			low_main_supply_flag <= low_main_supply_flag_now;
			low_supply_reset_pin_n <= !low_main_supply_flag_now;
			// one pulse a second is about 30.5 ppm
			trim_insert <= sec_tick && (coarse_digital_trim == DT_PLUS);
			trim_skip <= sec_tick && (coarse_digital_trim == DT_MINUS);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_bat_off;
		(filt[PIN_BAT] && backup_pin_disable) |=> (!fout_oe && !irq_oe);
	endproperty
	a_bat_off: assert property (p_bat_off) else $error("pins active on backup");

	property p_bat_on;
		(filt[PIN_BAT] && !backup_pin_disable && !filt[PIN_ALARM]) |=> irq_oe;
	endproperty
	a_bat_on: assert property (p_bat_on) else $error("irq lost on backup");

	property p_fo_off;
		(out_freq_select == FO_OFF) [*2] |-> !fout_oe;
	endproperty
	a_fo_off: assert property (p_fo_off) else $error("output not static");

	property p_stamp;
		(wr_en && (ptr == REG_MAIN) && shreg[MAIN_CLR_BIT]) |=> stamp_clear ##1 !stamp_clear;
	endproperty
	a_stamp: assert property (p_stamp) else $error("stamp clear not one pulse");

	property p_reserved;
		(wr_en && (ptr == REG_MAIN) && (wr_brown > BROWN_MAX)) |=>
			$stable(brownout_level_select);
	endproperty
	a_reserved: assert property (p_reserved) else $error("reserved code taken");

	property p_low_main_supply_flag;
		(filt[PIN_BROWN] && !filt[PIN_BAT]) |=> (low_main_supply_flag && !low_supply_reset_pin_n);
	endproperty
	a_low_main_supply_flag: assert property (p_low_main_supply_flag) else $error("brownout not flagged");

	property p_reconnect;
		rise[PIN_PWRUP] |=> !battery_disconnect;
	endproperty
	a_reconnect: assert property (p_reconnect) else $error("disconnect not cleared");

	property p_trim;
		(sec_tick && (coarse_digital_trim == DT_PLUS)) |=> (trim_insert && !trim_skip);
	endproperty
	a_trim: assert property (p_trim) else $error("insert pulse missing");

	property p_trim_excl;
		!(trim_insert && trim_skip) && !(trim_insert && $past(trim_insert));
	endproperty
	a_trim_excl: assert property (p_trim_excl) else $error("trim pulses overlap");

	property p_osc_code;
		((out_freq_select == FO_OSC) && pins_on) [*2] |-> (fout_oe == !filt_d[PIN_OSC]);
	endproperty
	a_osc_code: assert property (p_osc_code) else $error("fout not following osc");
	property p_slow_code;
		((out_freq_select == '1) && pins_on) [*2] |-> (fout_oe == !$past(div[DIV_W-1]));
	endproperty
	a_slow_code: assert property (p_slow_code) else $error("slow code off divider");
endmodule
`default_nettype wire

// file: sim/rtp_host.sv
// two-wire bus host model driving the register block
`timescale 1ns/1ps
`default_nettype none
module rtp_host (
	input wire logic core_clk, // bench clock
	input wire logic sda_line, // resolved data line, pulled up
	output logic scl_drv, // serial clock, host is sole master
	output logic sda_low // high pulls the data line low
);
	import rtp_pkg::*;
	initial begin
		scl_drv = 1'b1;
		sda_low = 1'b0;
	end
	task automatic hold(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// one bit: data moves only while clock is low, ten cycles high and twelve low
	task automatic bit_io(input logic b, output logic r);
		sda_low <= ~b;
		hold(10);
		scl_drv <= 1'b1;
		hold(10);
		r = sda_line;
		scl_drv <= 1'b0;
		hold(2);
	endtask
	// start and repeated start: release data first so the ack is not trampled
	task automatic start;
		sda_low <= 1'b0;
		hold(10);
		scl_drv <= 1'b1;
		hold(10);
		sda_low <= 1'b1;
		hold(10);
		scl_drv <= 1'b0;
		hold(2);
	endtask
	task automatic stop;
		sda_low <= 1'b1;
		hold(10);
		scl_drv <= 1'b1;
		hold(10);
		sda_low <= 1'b0;
		hold(10);
	endtask
	// eight bits msb first, then the acknowledge bit
	task automatic byte_io(input logic [7:0] d, input logic ab, output logic [7:0] q,
		output logic ak);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(ab, r);
		ak = ~r;
	endtask
	task automatic write_reg(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
		output logic ok);
		logic [7:0] q;
		logic k1;
		logic k2;
		logic k3;
		start();
		byte_io({a, 1'b0}, 1'b1, q, k1);
		byte_io(p, 1'b1, q, k2);
		byte_io(d, 1'b1, q, k3);
		stop();
		ok = k1 & k2 & k3;
	endtask
	// pointer set, repeated start, one byte read and closed with a nack
	task automatic read_reg(input logic [7:0] p, output logic [7:0] v);
		logic [7:0] q;
		logic k;
		start();
		byte_io({DEV_ADDR, 1'b0}, 1'b1, q, k);
		byte_io(p, 1'b1, q, k);
		start();
		byte_io({DEV_ADDR, 1'b1}, 1'b1, q, k);
		byte_io(8'hff, 1'b1, v, k);
		stop();
	endtask
endmodule
`default_nettype wire

// file: sim/rtp_ctrl_test.sv
// self-checking bench for the rtc output, supply and trim block
`timescale 1ns/1ps
`default_nettype none
module rtp_ctrl_test;
	import rtp_pkg::*;
	logic core_clk, rst_n, osc_32k, battery_mode, main_below_trip, main_power_up, alarm_irq_n;
	logic scl_drv, sda_low, sda_out, sda_oe, fout_out, fout_oe, irq_out, irq_oe;
	logic low_supply_reset_pin_n, low_main_supply_flag, stamp_clear, battery_disconnect;
	logic trim_insert, trim_skip;
	logic [2:0] brownout_level_select, batt_first_level_select, batt_second_level_select;
	logic [5:0] fine_analog_trim;
	logic [1:0] coarse_digital_trim;
	wire sda_line = ~(sda_low | (sda_oe & ~sda_out));
	int err_total = 0;
	int n_checks = 0;
	int stamp_n = 0;
	int hz [5] = '{32768, 4096, 1024, 64, 32};
	rtp_ctrl i_rtp_ctrl (.core_clk(core_clk), .rst_n(rst_n), .scl_in(scl_drv),
		.sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe), .osc_32k(osc_32k),
		.battery_mode(battery_mode), .main_below_trip(main_below_trip),
		.main_power_up(main_power_up), .alarm_irq_n(alarm_irq_n), .fout_out(fout_out),
		.fout_oe(fout_oe), .irq_out(irq_out), .irq_oe(irq_oe),
		.low_supply_reset_pin_n(low_supply_reset_pin_n),
		.low_main_supply_flag(low_main_supply_flag), .stamp_clear(stamp_clear),
		.brownout_level_select(brownout_level_select),
		.batt_first_level_select(batt_first_level_select),
		.batt_second_level_select(batt_second_level_select),
		.battery_disconnect(battery_disconnect), .fine_analog_trim(fine_analog_trim),
		.coarse_digital_trim(coarse_digital_trim), .trim_insert(trim_insert),
		.trim_skip(trim_skip));
	rtp_host i_rtp_host (.core_clk(core_clk), .sda_line(sda_line), .scl_drv(scl_drv),
		.sda_low(sda_low));
	////////////////////////////////////////////////////////////////////////////////
	// core clock 5 ns; oscillator sped up to 8 core cycles so dividers finish
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end
	initial begin
		osc_32k = 1'b0;
		forever #20 osc_32k = ~osc_32k;
	end
	// stamp clear is a pulse, so count it rather than poll it
	always @(posedge core_clk) begin
		if (stamp_clear === 1'b1) stamp_n++;
	end
	task automatic hold(input int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t %s seen %h expected %h", $time, m, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic ok;
		i_rtp_host.write_reg(DEV_ADDR, p, d, ok);
		chk(ok, 1, "write not acknowledged");
	endtask
	task automatic rdchk(input logic [7:0] p, input logic [7:0] e, input string m);
		logic [7:0] v;
		i_rtp_host.read_reg(p, v);
		chk(v, e, m);
	endtask
	// bounded wait for the frequency pin drive to reach a level
	task automatic till(input logic v, inout int n);
		while (fout_oe !== v && n < 20000) begin
			@(negedge core_clk);
			n++;
		end
	endtask
	// core cycles from one rising drive edge to the next
	task automatic meas(output int p);
		int a;
		a = 0;
		till(1'b0, a);
		till(1'b1, a);
		p = 0;
		till(1'b0, p);
		till(1'b1, p);
	endtask
	// any frequency or irq pin activity over a hundred cycles
	task automatic quiet(output logic h);
		h = 1'b0;
		repeat (100) begin
			@(negedge core_clk);
			h = h | fout_oe | irq_oe;
		end
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	initial begin
		#400000;
		err_total++;
		results();
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int p;
		logic ok;
		logic h;
		rst_n = 1'b0;
		battery_mode = 1'b0;
		main_below_trip = 1'b0;
		main_power_up = 1'b0;
		alarm_irq_n = 1'b1;
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		hold(10);
		for (int a = 8; a < 12; a++) rdchk(a[7:0], 8'h00, "reset value");
		// coarse trim written with sensing assumed off, as the host must
		wr(REG_TRIM, 8'hc5);
		chk(coarse_digital_trim, 2'h3, "coarse trim");
		chk(fine_analog_trim, 6'h05, "fine trim");
		rdchk(REG_TRIM, 8'hc5, "trim readback");
		// reserved first level dropped, other fields of the byte taken
		wr(REG_BATT, 8'h7e);
		rdchk(REG_BATT, 8'h46, "reserved battery code");
		chk(battery_disconnect, 1'b1, "disconnect set");
		chk(batt_second_level_select, 3'h6, "second level");
		@(posedge core_clk);
		main_power_up <= 1'b1;
		hold(10);
		chk(battery_disconnect, 1'b0, "power-up clear");
		@(posedge core_clk);
		main_power_up <= 1'b0;
		wr(REG_BATT, 8'h35);
		rdchk(REG_BATT, 8'h35, "battery levels");
		wr(REG_MAIN, 8'h05);
		chk(brownout_level_select, 3'h5, "brownout top code");
		wr(REG_MAIN, 8'h86);
		rdchk(REG_MAIN, 8'h05, "reserved brownout code");
		chk(stamp_n, 1, "stamp clear pulses");
		wr(REG_UNMAPPED, 8'h5a);
		rdchk(REG_UNMAPPED, 8'h00, "unmapped read");
		i_rtp_host.write_reg(DEV_ADDR ^ 7'h01, REG_TRIM, 8'h00, ok);
		chk(ok, 1'b0, "foreign address acked");
		rdchk(REG_TRIM, 8'hc5, "foreign write landed");
		// brownout only counts on main supply
		@(posedge core_clk);
		main_below_trip <= 1'b1;
		hold(10);
		chk(low_main_supply_flag, 1'b1, "brownout flag");
		chk(low_supply_reset_pin_n, 1'b0, "reset pin");
		rdchk(REG_STATUS, 8'h08, "status flag");
		@(posedge core_clk);
		battery_mode <= 1'b1;
		hold(10);
		chk(low_main_supply_flag, 1'b0, "flag on battery");
		@(posedge core_clk);
		battery_mode <= 1'b0;
		main_below_trip <= 1'b0;
		// output periods from the selected frequencies, oscillator at 8 cycles
		for (int k = 1; k < 6; k++) begin
			wr(k[7:0], 8'h00);
			wr(REG_INT, k[7:0]);
			meas(p);
			chk(p, 8 * 32768 / hz[k - 1], "output period");
		end
		wr(REG_INT, 8'h00);
		quiet(h);
		chk(h, 1'b0, "code zero active");
		// slowest code: top divider bit is still low this early in the run
		wr(REG_INT, 8'h0f);
		chk(fout_oe, 1'b1, "slowest code level");
		// disable bit set on backup supply silences both pins
		wr(REG_INT, 8'h11);
		@(posedge core_clk);
		battery_mode <= 1'b1;
		alarm_irq_n <= 1'b0;
		// let the backup level pass the pin filter before watching
		hold(10);
		quiet(h);
		chk(h, 1'b0, "pins not disabled");
		wr(REG_INT, 8'h01);
		meas(p);
		chk(p, 8, "output on backup");
		chk(irq_oe, 1'b1, "irq on backup");
		// open-drain drive values never go high
		chk({sda_out, fout_out, irq_out}, 3'h0, "drive value high");
		// a trim pulse is due only once per 32768 oscillator edges
		chk({trim_insert, trim_skip}, 2'h0, "trim pulse too early");
		results();
	end
endmodule
`default_nettype wire
